// *** rtl/ptbp_backend_port.v ***
// Purpose : Back-end transaction port of a 32-bit PCI target core
// Assumes : Single PCI clock; the front end hands in decoded bus phases
// Notes   : Write words pass a 4-word FIFO before reaching user logic
`timescale 1ns/10ps
`include "ptbp_defines.vh"
module ptbp_backend_port #(
  parameter FIFO_DEPTH = `PTBP_FIFO_DEPTH,
  parameter FIFO_AW    = 2
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Front-end request: start of transaction
  input  wire        fe_start_valid,
  output wire        fe_start_ready,
  input  wire [31:0] fe_addr,
  input  wire [3:0]  fe_cmd,
  // Front-end data phases
  input  wire        fe_data_valid,
  output wire        fe_data_ready,
  input  wire [31:0] fe_wdata,
  input  wire [3:0]  fe_byte_en_n,
  input  wire        fe_last,
  // Front-end read return and busy flag
  output reg         fe_rdata_valid,
  output reg  [31:0] fe_rdata,
  output reg         fe_busy,
  // Back-end user port
  output reg  [31:0] addr_wdata_port,
  output reg  [3:0]  cmd_byte_en_port,
  output reg         addr_valid,
  output reg         addr_inc,
  output reg         user_write,
  output reg         config_write,
  input  wire        read_cmd_hit,
  input  wire        write_cmd_hit,
  input  wire        user_select,
  input  wire        user_ready,
  input  wire [31:0] user_read_data,
  input  wire [31:0] config_read_data
);

  ////////////////////////////////////////////////////////////////////////////
  // State and storage

  localparam ST_IDLE  = 2'd0;
  localparam ST_WRITE = 2'd1;
  localparam ST_READ  = 2'd2;
  localparam ST_DONE  = 2'd3;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg         is_cfg_q;
  reg         rd_last_q;
  wire        fifo_out_valid;
  wire [36:0] fifo_out_data;
  wire        fifo_pop;
  wire        rd_xfer;
  wire        fe_data_ready_w;

  // Configuration commands are routed to the config space, not user logic
  function ptbp_is_cfg;
    input [3:0] c;
    begin
      ptbp_is_cfg = (c == `PTBP_CMD_CFG_READ) || (c == `PTBP_CMD_CFG_WRITE);
    end
  endfunction

  // Write direction by the PCI command encoding (low bit set on writes)
  function ptbp_is_wr;
    input [3:0] c;
    begin
      ptbp_is_wr = (c == `PTBP_CMD_IO_WRITE) || (c == `PTBP_CMD_MEM_WRITE) ||
                   (c == `PTBP_CMD_CFG_WRITE) || (c == `PTBP_CMD_MEM_WRI);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write data buffer: FIFO back-pressure stalls the front end's data phases
  // The drain never stalls, so a deeper buffer would only cost area; four
  // words still ride out a front end that delivers in short bursts

  ptbp_fifo #(
    .WIDTH (37),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_wr_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (fe_data_valid & (state_q == ST_WRITE)),
    .in_ready  (fe_data_ready_w),
    .in_data   ({fe_last, fe_byte_en_n, fe_wdata}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // Writes drain one word per cycle; reads pace on the user handshake
  // A read data phase is refused while an offer is still open to the user
  assign fifo_pop       = fifo_out_valid & (state_q == ST_WRITE);
  assign rd_xfer        = addr_inc & user_ready & (state_q == ST_READ);
  assign fe_data_ready  = (state_q == ST_WRITE) ? fe_data_ready_w :
                          (state_q == ST_READ) & ~addr_inc;
  assign fe_start_ready = (state_q == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Transaction sequencing

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (fe_start_valid)
          state_d = ptbp_is_wr(fe_cmd) ? ST_WRITE : ST_READ;
      ST_WRITE:
        if (fifo_pop & fifo_out_data[36])
          state_d = ST_DONE;
      ST_READ:
        if (rd_xfer & rd_last_q)
          state_d = ST_DONE;
      ST_DONE:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // Port drive: strobe first cycle, then data phases
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q          <= ST_IDLE;
      is_cfg_q         <= 1'b0;
      rd_last_q        <= 1'b0;
      addr_wdata_port  <= `PTBP_RST_WORD;
      cmd_byte_en_port <= `PTBP_RST_NIB;
      addr_valid       <= 1'b0;
      addr_inc         <= 1'b0;
      user_write       <= 1'b0;
      config_write     <= 1'b0;
      fe_rdata_valid   <= 1'b0;
      fe_rdata         <= `PTBP_RST_WORD;
      fe_busy          <= 1'b0;
    end
    else
    begin
      state_q        <= state_d;
      addr_valid     <= 1'b0;
      fe_rdata_valid <= 1'b0;
      fe_busy        <= (state_d != ST_IDLE);
      if (state_q != ST_WRITE)
        addr_inc <= 1'b0;
      case (state_q)
        ST_IDLE:
          if (fe_start_valid)
          begin
            addr_wdata_port  <= fe_addr;
            cmd_byte_en_port <= fe_cmd;
            addr_valid       <= 1'b1;
            is_cfg_q         <= ptbp_is_cfg(fe_cmd);
          end
        ST_WRITE:
        begin
          // Hit sampled in the strobe cycle, held for the burst
          if (addr_valid)
          begin
            user_write   <= write_cmd_hit & user_select & ~is_cfg_q;
            config_write <= is_cfg_q;
          end
          // Advance pulses once per delivered word; user cannot refuse it
          addr_inc <= fifo_pop;
          if (fifo_pop)
          begin
            addr_wdata_port  <= fifo_out_data[31:0];
            cmd_byte_en_port <= fifo_out_data[35:32];
          end
        end
        ST_READ:
        begin
          // Offer acceptance; hold it until the user supplies a word
          if (rd_xfer)
          begin
            addr_inc       <= 1'b0;
            fe_rdata_valid <= 1'b1;
            // Both sources share one handshake; only the word's origin differs
            fe_rdata       <= is_cfg_q ? config_read_data : user_read_data;
          end
          else if (addr_inc)
            addr_inc <= 1'b1;
          else if (fe_data_valid)
          begin
            addr_inc         <= 1'b1;
            cmd_byte_en_port <= fe_byte_en_n;
            rd_last_q        <= fe_last;
          end
        end
        ST_DONE:
        begin
          user_write   <= 1'b0;
          config_write <= 1'b0;
          rd_last_q    <= 1'b0;
        end
        default:
          user_write <= 1'b0;
      endcase
    end
  end

endmodule // ptbp_backend_port

// *** pkg/ptbp_defines.vh ***
// Purpose : Shared constants for the PCI target back-end port
// Assumes : Included by the back-end port; the FIFO takes its sizes as parameters
// Notes   : Command codes follow the PCI bus command encoding
`ifndef PTBP_DEFINES_VH
`define PTBP_DEFINES_VH

// PCI command codes on the command/byte-enable port
`define PTBP_CMD_IO_READ    4'h2
`define PTBP_CMD_IO_WRITE   4'h3
`define PTBP_CMD_MEM_READ   4'h6
`define PTBP_CMD_MEM_WRITE  4'h7
`define PTBP_CMD_CFG_READ   4'hA
`define PTBP_CMD_CFG_WRITE  4'hB
`define PTBP_CMD_MEM_RDM    4'hC
`define PTBP_CMD_MEM_RDL    4'hE
`define PTBP_CMD_MEM_WRI    4'hF

// Front-end request kinds
`define PTBP_REQ_READ       1'b0
`define PTBP_REQ_WRITE      1'b1

// Default depth and widths
`define PTBP_FIFO_DEPTH     4
`define PTBP_DATA_W         32
`define PTBP_BE_W           4

// Reset values
`define PTBP_RST_WORD       32'h0000_0000
`define PTBP_RST_NIB        4'hF

`endif

// *** rtl/ptbp_fifo.v ***
// Purpose : Small synchronous FIFO with valid/ready on both sides
// Assumes : One clock, synchronous active-high reset
// Notes   : Full and empty are exact; no bypass, one cycle latency
`timescale 1ns/10ps
module ptbp_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;
  wire            push;
  wire            pop;

  // Pointer wrap shared by both ends
  function [AW-1:0] ptbp_next;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - 1'b1)
        ptbp_next = {AW{1'b0}};
      else
        ptbp_next = p + 1'b1;
    end
  endfunction

  assign in_ready  = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage is not reset; only pointers and the count carry control state
  always @(posedge ref_clk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

  // Pointer and occupancy update
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_q <= ptbp_next(wr_ptr_q);
      if (pop)
        rd_ptr_q <= ptbp_next(rd_ptr_q);
      if (push & ~pop)
        count_q <= count_q + 1'b1;
      else if (pop & ~push)
        count_q <= count_q - 1'b1;
    end
  end

endmodule // ptbp_fifo

// *** verification/ptbp_port_assertions.sv ***
// Purpose: Port assertions for the PCI target back-end port
// Assumes: Sees only the top-level ports
// Notes  : Direction and space are kept from the accepted start command
`timescale 1ns/10ps
module ptbp_port_checker (
  // Clock, reset and front end
  input wire        ref_clk,
  input wire        rst,
  input wire        fe_start_valid,
  input wire        fe_start_ready,
  input wire [31:0] fe_addr,
  input wire [3:0]  fe_cmd,
  input wire        fe_rdata_valid,
  input wire [31:0] fe_rdata,
  // User side
  input wire [31:0] addr_wdata_port,
  input wire [3:0]  cmd_byte_en_port,
  input wire        addr_valid,
  input wire        addr_inc,
  input wire        user_write,
  input wire        config_write,
  input wire        user_ready,
  input wire [31:0] user_read_data,
  input wire [31:0] config_read_data
);
  reg wr_q;
  reg cfg_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Odd codes write; A and B reach the configuration space
  always @(posedge ref_clk)
  begin
    if (fe_start_valid && fe_start_ready)
    begin
      wr_q  <= fe_cmd[0];
      cfg_q <= (fe_cmd[3:1] == 3'h5);
    end
  end
  addr_cmd_a: assert property (fe_start_valid && fe_start_ready |=> addr_valid
    && addr_wdata_port == $past(fe_addr) && cmd_byte_en_port == $past(fe_cmd)) else $error("address phase wrong");
  strobe_once_a: assert property (addr_valid |=> !addr_valid) else $error("address strobe too long");
  strobe_cause_a: assert property (addr_valid |-> $past(fe_start_valid && fe_start_ready))
    else $error("address strobe without start");
  read_hold_a: assert property (addr_inc && !user_ready && !wr_q |=> addr_inc)
    else $error("read advance dropped");
  read_return_a: assert property (addr_inc && user_ready && !wr_q |=> fe_rdata_valid
    && fe_rdata == $past(cfg_q ? config_read_data : user_read_data)) else $error("read word wrong");
  read_cause_a: assert property (fe_rdata_valid |-> $past(addr_inc && user_ready))
    else $error("read word without handshake");
  user_span_a: assert property (user_write |-> wr_q && !cfg_q) else $error("user write wrong");
  cfg_span_a: assert property (config_write |-> wr_q && cfg_q) else $error("config write wrong");
endmodule // ptbp_port_checker
bind ptbp_backend_port ptbp_port_checker u_chk (.ref_clk, .rst, .fe_start_valid, .fe_start_ready, .fe_addr,
  .fe_cmd, .fe_rdata_valid, .fe_rdata, .addr_wdata_port, .cmd_byte_en_port, .addr_valid, .addr_inc,
  .user_write, .config_write, .user_ready, .user_read_data, .config_read_data);

// *** verification/ptbp_user_model.sv ***
// Purpose: Back-end user logic model
// Assumes: Window at base 0x1000xxxx
// Notes  : slow makes ready wait two cycles per read word
`timescale 1ns/10ps
module ptbp_user_model (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        slow,
  input  wire        acc_en,
  input  wire [31:0] addr_wdata_port,
  input  wire [3:0]  cmd_byte_en_port,
  input  wire        addr_valid,
  input  wire        addr_inc,
  input  wire        user_write,
  output wire        read_cmd_hit,
  output wire        write_cmd_hit,
  output wire        user_select,
  output wire        user_ready,
  output wire [31:0] user_read_data,
  output reg  [31:0] addr_q,
  output reg  [7:0]  wr_count,
  output reg  [31:0] last_word
);
  reg       rd_q, wr_q, sel_q, cr_q;
  reg [1:0] wait_q;
  wire [3:0] cmd = cmd_byte_en_port;
  // Explicit command codes; a single bit test would also catch configuration reads and writes
  wire rd_cmd = (cmd == 4'h2) || (cmd == 4'h6) || (cmd == 4'hC) || (cmd == 4'hE);
  wire wr_cmd = (cmd == 4'h3) || (cmd == 4'h7) || (cmd == 4'hF);
  // Decode live in the strobe cycle, then held for the access
  assign read_cmd_hit  = addr_valid ? rd_cmd : rd_q;
  assign write_cmd_hit = addr_valid ? wr_cmd : wr_q;
  assign user_select   = addr_valid ? acc_en && addr_wdata_port[31:16] == 16'h1000 : sel_q;
  // Configuration space answers its reads through the same ready handshake
  assign user_ready    = (rd_q || cr_q) && addr_inc && (!slow || wait_q == 2'h2);
  // Inverse pattern when not ready, so a stale word cannot pass
  assign user_read_data = user_ready ? addr_q ^ 32'hA5A5_0000 : ~(addr_q ^ 32'hA5A5_0000);
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      {rd_q, wr_q, sel_q, cr_q, wait_q, wr_count} <= 0;
    end
    else
    begin
      {rd_q, wr_q, sel_q} <= {read_cmd_hit, write_cmd_hit, user_select};
      cr_q <= addr_valid ? (cmd == 4'hA) : cr_q;
      wait_q <= (addr_inc && !user_ready) ? wait_q + 2'h1 : 2'h0;
      if (addr_valid)
        addr_q <= addr_wdata_port;
      else if (addr_inc && (user_write || user_ready))
        addr_q <= addr_q + 32'h4;
      if (addr_inc && user_write)
      begin
        wr_count  <= wr_count + 8'h1;
        last_word <= addr_wdata_port;
      end
    end
  end
endmodule // ptbp_user_model

// *** verification/pci_target_backend_port_tb_top.sv ***
// Purpose: Self-checking bench for the back-end port
// Assumes: 250 MHz clock, inputs driven 1 ns after the edge
// Notes  : Expectations come from the base address and burst lengths
`timescale 1ns/10ps
module pci_target_backend_port_tb_top;
  reg ref_clk = 0, rst = 1, slow = 0, acc_en = 1;
  reg fe_start_valid = 0, fe_data_valid = 0, fe_last = 0;
  reg [31:0] fe_addr = 0, fe_wdata = 0;
  reg [3:0] fe_cmd = 0, fe_byte_en_n = 4'hF;
  wire fe_start_ready, fe_data_ready, fe_rdata_valid, fe_busy, addr_valid, addr_inc, user_write, config_write;
  wire read_cmd_hit, write_cmd_hit, user_select, user_ready;
  wire [31:0] fe_rdata, addr_wdata_port, user_read_data, addr_q, last_word;
  wire [3:0] cmd_byte_en_port;
  wire [7:0] wr_count;
  wire [31:0] config_read_data = 32'hC0DE_0001;
  integer err_total = 0, samples_checked = 0, i;
  reg cfg_seen;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (config_write) cfg_seen <= 1'b1;
  ptbp_backend_port dut (.ref_clk, .rst, .fe_start_valid, .fe_start_ready, .fe_addr, .fe_cmd, .fe_data_valid,
    .fe_data_ready, .fe_wdata, .fe_byte_en_n, .fe_last, .fe_rdata_valid, .fe_rdata, .fe_busy, .addr_wdata_port,
    .cmd_byte_en_port, .addr_valid, .addr_inc, .user_write, .config_write, .read_cmd_hit, .write_cmd_hit,
    .user_select, .user_ready, .user_read_data, .config_read_data);
  ptbp_user_model u_usr (.ref_clk, .rst, .slow, .acc_en, .addr_wdata_port, .cmd_byte_en_port, .addr_valid,
    .addr_inc, .user_write, .read_cmd_hit, .write_cmd_hit, .user_select, .user_ready, .user_read_data,
    .addr_q, .wr_count, .last_word);
  task summarize;
  begin
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task chk(input string what, input [31:0] seen, input [31:0] exp);
  begin
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask
  // Bounded wait for a start, data or return flag
  task wait_on(input integer k);
    integer n;
  begin
    n = 0;
    while (!(k == 0 ? fe_start_ready : k == 1 ? fe_data_ready : fe_rdata_valid) && n < 60)
    begin
      @(posedge ref_clk); #1; n++;
    end
    if (n == 60)
    begin
      err_total++;
      summarize;
    end
  end
  endtask
  task phase(input [31:0] a, input [3:0] c, input integer k);
  begin
    {fe_addr, fe_cmd, fe_wdata, fe_byte_en_n} = {a, c, a ^ 32'h5A5A_5A5A, c};
    if (k == 0) fe_start_valid = 1; else fe_data_valid = 1;
    wait_on(k);
    @(posedge ref_clk); #1;
    {fe_start_valid, fe_data_valid} = 0;
    // Let an edge pass low, so the next phase never lowers and raises at once
    @(posedge ref_clk); #1;
  end
  endtask
  // Burst of n words; reads check each return, writes the far side afterwards
  task burst(input [31:0] a, input [3:0] c, input integer n, input integer got);
    reg [7:0] base;
  begin
    base = wr_count;
    cfg_seen = 0;
    phase(a, c, 0);
    chk("busy in access", fe_busy, 1);
    for (i = 0; i < n; i++)
    begin
      fe_last = (i == n - 1);
      phase(a + 4 * i, c, 1);
      if (!c[0])
      begin
        wait_on(2);
        chk("read word", fe_rdata, c[3:1] == 3'h5 ? config_read_data : (a + 4 * i) ^ 32'hA5A5_0000);
      end
    end
    fe_last = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    chk("busy after access", fe_busy, 0);
    if (c[0]) chk("word count", wr_count - base, got);
    if (got > 0) chk("last word", last_word, (a + 4 * n - 4) ^ 32'h5A5A_5A5A);
    if (got > 0 || !c[0]) chk("end address", addr_q, a + 4 * n);
    chk("config write seen", cfg_seen, c == 4'hB);
  end
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1 rst = 0;
    burst(32'h1000_0100, 4'h7, 6, 6);
    burst(32'h1000_0200, 4'h3, 1, 1);
    burst(32'h1000_0300, 4'hF, 3, 3);
    burst(32'h2000_0000, 4'h7, 2, 0);
    burst(32'h0000_0010, 4'hB, 2, 0);
    burst(32'h1000_0400, 4'h6, 3, 0);
    slow = 1;
    burst(32'h1000_0500, 4'h2, 2, 0);
    burst(32'h1000_0600, 4'hC, 3, 0);
    burst(32'h1000_0700, 4'hE, 1, 0);
    burst(32'h0000_0020, 4'hA, 1, 0);
    summarize;
  end
endmodule // pci_target_backend_port_tb_top
